// *** common/wdr_pkg.sv ***
// shared constants and types for the wake delay and reset status block
package wdr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int CSD_NS = 2000;
  localparam int OSC_NS = 20000;
  localparam int PLL_NS = 100000;
  localparam int SETTLE_NS = 100000;
  localparam int CSD_CYC = (CSD_NS + CLK_NS - 1) / CLK_NS;
  localparam int OSC_CYC = (OSC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PLL_CYC_DEF = (PLL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC_DEF = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TW = 20;
  // timer channels
  localparam int T_CSD = 0;
  localparam int T_OSC = 1;
  localparam int T_PLL = 2;
  localparam int T_SETTLE = 3;
  localparam int NT = 4;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_RCC = 8'h00;
  localparam logic [ADDR_W-1:0] A_OSC = 8'h04;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h0c;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // reset_cause_control bits
  localparam int RCC_W = 8;
  localparam int B_PRIO = 7;
  localparam int B_SWBO = 6;
  localparam int B_INSTR = 4;
  localparam int B_WDOG = 3;
  localparam int B_SLEEP = 2;
  localparam int B_PWRUP = 1;
  localparam int B_DIP = 0;
  localparam logic [RCC_W-1:0] RCC_RST = 8'h5c;
  localparam logic [RCC_W-1:0] RCC_WMASK = 8'hd3;
  // oscillator control/status fields
  localparam int F_FREQ = 0;
  localparam int FREQ_W = 3;
  localparam logic [FREQ_W-1:0] FREQ_1MHZ = 3'h3;
  localparam int F_XRDY = 8;
  localparam int F_FRDY = 9;
  localparam int F_HOLD = 10;
  localparam int F_CAUSE = 12;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int I_WAKE = 0;
  localparam int I_XRDY = 1;
  localparam int I_FRDY = 2;
  localparam int I_WDT = 3;
  // brownout configuration codes
  localparam logic [1:0] BO_CFG_OFF = 2'h0;
  localparam logic [1:0] BO_CFG_SW = 2'h1;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PRE_PRIMARY = 2'h0, PRE_SLOW = 2'h1, PRE_FAST = 2'h2, PRE_NONE = 2'h3
  } wdr_pre_e;
  typedef enum logic [1:0] {
    POST_CRYSTAL = 2'h0, POST_PLL = 2'h1, POST_EXT = 2'h2, POST_FAST = 2'h3
  } wdr_post_e;
  typedef enum logic [2:0] {
    CAUSE_PWRUP = 3'h0, CAUSE_EXT_RUN = 3'h1, CAUSE_EXT_PM = 3'h2,
    CAUSE_WDT = 3'h3, CAUSE_DIP = 3'h4, CAUSE_INSTR = 3'h5,
    CAUSE_STK_FULL = 3'h6, CAUSE_STK_UNDER = 3'h7
  } wdr_cause_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, ST_OSC = 3'h2, ST_PLL = 3'h4
  } wdr_st_e;
endpackage

// *** common/wdr_tmr_if.sv ***
// start and status lines between the wake sequencer and its timers
`timescale 1ns/1ps
interface wdr_tmr_if;
  import wdr_pkg::*;
  logic [NT-1:0] start;
  logic [NT-1:0] busy;
  logic [NT-1:0] done;
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface

// *** rtl/wdr_sync.sv ***
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module wdr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input logic aclk,
  input logic aresetn,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_q <= RST[i];
        q[i] <= RST[i];
      end else begin
        meta_q <= d[i];
        q[i] <= meta_q;
      end
    end
  end
endmodule // wdr_sync

// *** rtl/wdr_tmr.sv ***
// bank of down-counting delay timers, one per delay kind
`timescale 1ns/1ps
module wdr_tmr
  import wdr_pkg::*;
#(
  parameter logic [NT*TW-1:0] LENS = '0
) (
  input logic aclk,
  input logic aresetn,
  wdr_tmr_if.tmr t
);
  // restart on start reloads the full length, even mid-count
  for (genvar i = 0; i < NT; i++) begin : g_ch
    logic [TW-1:0] cnt_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q <= '0;
      end else if (t.start[i]) begin
        cnt_q <= LENS[i*TW +: TW];
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
    assign t.busy[i] = (cnt_q != '0);
    assign t.done[i] = (cnt_q == TW'(1));
  end
endmodule // wdr_tmr

// *** rtl/wdr_top.sv ***
// wake delay selection and reset cause status with axi4-lite access
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

// Summary of operation
// - primary idle reset wake costs only cpu wake delay; ready flag by target.
// - crystal wake from slow, fast or sleep waits start-up, plus lock for pll.
// - pll lock interval timed by its own timer after start-up count.
// - cpu wake delay on every wake except fast to fast, concurrent with other delays.
// - fast oscillator frequency select resets to 1 MHz.
// - wake to fast oscillator runs on; stable flag set after settle time from slow or sleep, at once otherwise.
// - fast stays fast means no delay; external or rc costs cpu delay.
// - eight reset causes are told apart.
// - low five status bits record which reset events happened.
// - events clear flags; software sets them again afterwards.
// - bit 7 priority enable resets to 0 and drives priority mode.
// - bit 6 switches brownout only when config field is 01.
// - bit 5 reads 0; 4,1,0 writable; 3,2 read-only; reset values.
// - watchdog flag set by power-up, clear or sleep; cleared by timeout.
// - sleep flag set by power-up or clear; cleared by sleep.
// - brownout leaves supply dip flag 0 with power-up flag still 1.
module wdr_top
  import wdr_pkg::*;
#(
  parameter int PLL_CYC = PLL_CYC_DEF,
  parameter int SETTLE_CYC = SETTLE_CYC_DEF
) (
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  output logic awready,
  input logic [ADDR_W-1:0] awaddr,
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  input logic arvalid,
  output logic arready,
  input logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input logic wake_req,
  input wdr_pre_e pre_src,
  input wdr_post_e post_src,
  input logic pm_mode,
  input logic external_reset_pin_n,
  input logic wdt_timeout,
  input logic clrwdt_instr,
  input logic sleep_instr,
  input logic reset_instr,
  input logic brownout_evt,
  input logic stack_full,
  input logic stack_underflow,
  input logic [1:0] brownout_config_field,
  output logic exec_hold,
  output logic crystal_ready_flag,
  output logic fast_internal_stable_flag,
  output logic [FREQ_W-1:0] fast_osc_freq_sel,
  output logic priority_levels_enable,
  output logic brownout_enable,
  output logic irq
);
  localparam logic [NT*TW-1:0] LENS = {TW'(SETTLE_CYC), TW'(PLL_CYC),
    TW'(OSC_CYC), TW'(CSD_CYC)};

  logic aw_got_q, w_got_q, bvalid_q, rvalid_q, wr_fire, ar_fire;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_val;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic rd_hit, wr_hit, wr_rcc, wr_osc, wr_mask, rd_stat;
  logic [RCC_W-1:0] rcc_q;
  logic [FREQ_W-1:0] freq_q;
  logic [IRQ_W-1:0] stat_q, mask_q, ev;
  wdr_cause_e cause_q;
  wdr_st_e st_q;
  wdr_post_e post_q;
  logic hold_q, xrdy_q, frdy_q, bo_en_q;
  logic ext_s, ext_d_q, ext_fall;
  logic wake_go, same_fast, osc_restart, osc_done, chain_end;
  logic start_csd, start_osc, start_pll, start_settle, hold_d;
  logic xrdy_set, xrdy_clr, frdy_set, frdy_clr;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign awready = !aw_got_q && !bvalid_q;
  assign wready = !w_got_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign ar_fire = arvalid && !rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_got_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end
  end

  assign wr_hit = (awaddr_q == A_RCC) || (awaddr_q == A_OSC) ||
    (awaddr_q == A_STAT) || (awaddr_q == A_MASK);
  // only byte lane 0 carries writable fields
  assign wr_rcc = wr_fire && (awaddr_q == A_RCC) && wstrb_q[0];
  assign wr_osc = wr_fire && (awaddr_q == A_OSC) && wstrb_q[0];
  assign wr_mask = wr_fire && (awaddr_q == A_MASK) && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OK;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OK : RESP_ERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = '0;
    case (araddr)
      A_RCC: rd_val[RCC_W-1:0] = rcc_q;
      A_OSC: begin
        rd_val[F_FREQ +: FREQ_W] = freq_q;
        rd_val[F_XRDY] = xrdy_q;
        rd_val[F_FRDY] = frdy_q;
        rd_val[F_HOLD] = hold_q;
        rd_val[F_CAUSE +: 3] = cause_q;
      end
      A_STAT: rd_val[IRQ_W-1:0] = stat_q;
      A_MASK: rd_val[IRQ_W-1:0] = mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OK;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // reset cause and control register
  // ---------------------------------------------------------------
  // later assignments win: a hardware event beats a software set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcc_q <= RCC_RST;
    end else begin
      if (wr_rcc) begin
        rcc_q <= (rcc_q & ~RCC_WMASK) | (wdata_q[RCC_W-1:0] & RCC_WMASK);
      end
      if (clrwdt_instr) begin
        rcc_q[B_WDOG] <= 1'b1;
        rcc_q[B_SLEEP] <= 1'b1;
      end
      if (sleep_instr) begin
        rcc_q[B_WDOG] <= 1'b1;
        rcc_q[B_SLEEP] <= 1'b0;
      end
      if (wdt_timeout) begin
        rcc_q[B_WDOG] <= 1'b0;
      end
      if (reset_instr) begin
        rcc_q[B_INSTR] <= 1'b0;
      end
      if (brownout_evt) begin
        rcc_q[B_DIP] <= 1'b0;
      end
    end
  end

  assign priority_levels_enable = rcc_q[B_PRIO];

  // software bit only counts in the software-controlled config
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_en_q <= 1'b0;
    end else begin
      case (brownout_config_field)
        BO_CFG_OFF: bo_en_q <= 1'b0;
        BO_CFG_SW: bo_en_q <= rcc_q[B_SWBO];
        default: bo_en_q <= 1'b1;
      endcase
    end
  end
  assign brownout_enable = bo_en_q;

  wdr_sync #(.W(1), .RST(1'b1)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(external_reset_pin_n),
    .q(ext_s)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_d_q <= 1'b1;
    end else begin
      ext_d_q <= ext_s;
    end
  end
  assign ext_fall = ext_d_q && !ext_s;

  // a power-up is the only cause recorded by reset itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= CAUSE_PWRUP;
    end else if (stack_underflow) begin
      cause_q <= CAUSE_STK_UNDER;
    end else if (stack_full) begin
      cause_q <= CAUSE_STK_FULL;
    end else if (reset_instr) begin
      cause_q <= CAUSE_INSTR;
    end else if (brownout_evt) begin
      cause_q <= CAUSE_DIP;
    end else if (wdt_timeout && !pm_mode) begin
      cause_q <= CAUSE_WDT;
    end else if (ext_fall) begin
      cause_q <= pm_mode ? CAUSE_EXT_PM : CAUSE_EXT_RUN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_q <= FREQ_1MHZ;
    end else if (wr_osc) begin
      freq_q <= wdata_q[F_FREQ +: FREQ_W];
    end
  end
  assign fast_osc_freq_sel = freq_q;

  // ---------------------------------------------------------------
  // wake delay selection
  // ---------------------------------------------------------------
  wdr_tmr_if tmr ();
  wdr_tmr #(.LENS(LENS)) u_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(tmr)
  );

  // a wake request while a wake is still held is dropped
  assign wake_go = wake_req && (st_q == ST_IDLE) && !tmr.busy[T_CSD];
  assign same_fast = (pre_src == PRE_FAST) &&
    (post_src == POST_FAST);
  assign osc_restart = (pre_src != PRE_PRIMARY) &&
    ((post_src == POST_CRYSTAL) || (post_src == POST_PLL));
  assign start_csd = wake_go && !same_fast;
  assign start_osc = wake_go && osc_restart;
  assign start_settle = wake_go && (post_src == POST_FAST) &&
    ((pre_src == PRE_SLOW) || (pre_src == PRE_NONE));
  assign osc_done = (st_q == ST_OSC) && tmr.done[T_OSC];
  assign start_pll = osc_done && (post_q == POST_PLL);
  assign chain_end = (osc_done && (post_q != POST_PLL)) ||
    ((st_q == ST_PLL) && tmr.done[T_PLL]);
  assign tmr.start[T_CSD] = start_csd;
  assign tmr.start[T_OSC] = start_osc;
  assign tmr.start[T_PLL] = start_pll;
  assign tmr.start[T_SETTLE] = start_settle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: if (start_osc) st_q <= ST_OSC;
        ST_OSC: if (osc_done) st_q <= start_pll ? ST_PLL : ST_IDLE;
        ST_PLL: if (tmr.done[T_PLL]) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      post_q <= POST_CRYSTAL;
    end else if (wake_go) begin
      post_q <= post_src;
    end
  end

  // settle time does not hold execution; cpu and oscillator delays overlap
  assign hold_d = start_csd || start_osc ||
    (tmr.busy[T_CSD] && !tmr.done[T_CSD]) ||
    ((st_q != ST_IDLE) && !chain_end);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end
  assign exec_hold = hold_q;

  assign xrdy_set = chain_end ||
    (tmr.done[T_CSD] && (post_q == POST_EXT)) ||
    (wake_go && (pre_src == PRE_PRIMARY) && (post_src != POST_FAST));
  assign xrdy_clr = wake_go && (osc_restart || (post_src == POST_FAST));
  assign frdy_set = tmr.done[T_SETTLE] || (wake_go &&
    (post_src == POST_FAST) &&
    ((pre_src == PRE_FAST) || (pre_src == PRE_PRIMARY)));
  assign frdy_clr = start_settle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xrdy_q <= 1'b0;
    end else if (xrdy_set) begin
      xrdy_q <= 1'b1;
    end else if (xrdy_clr) begin
      xrdy_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frdy_q <= 1'b0;
    end else if (frdy_set) begin
      frdy_q <= 1'b1;
    end else if (frdy_clr) begin
      frdy_q <= 1'b0;
    end
  end
  assign crystal_ready_flag = xrdy_q;
  assign fast_internal_stable_flag = frdy_q;

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  assign ev[I_WAKE] = hold_q && !hold_d;
  assign ev[I_XRDY] = xrdy_set;
  assign ev[I_FRDY] = frdy_set;
  assign ev[I_WDT] = wdt_timeout;
  assign rd_stat = ar_fire && (araddr == A_STAT);

  // event in the clearing read cycle survives: it was not in the data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else if (rd_stat) begin
      stat_q <= ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= wdata_q[IRQ_W-1:0];
    end
  end
  assign irq = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  localparam int CSD_M1 = CSD_CYC - 1;
  logic [TW-1:0] osc_n_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || st_q != ST_OSC) begin
      osc_n_q <= '0;
    end else begin
      osc_n_q <= osc_n_q + 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  csd_hold_a: assert property (start_csd && !start_osc |=>
    exec_hold ##CSD_M1 exec_hold ##1 !exec_hold)
    else $error("cpu wake hold length wrong");
  fast_free_a: assert property (wake_go && same_fast |=>
    !exec_hold) else $error("fast to fast wake held");
  osc_len_a: assert property (osc_done |->
    osc_n_q == TW'(OSC_CYC - 1)) else $error("start-up count wrong");
  pll_chain_a: assert property (start_pll |=>
    st_q == ST_PLL && tmr.busy[T_PLL] && !crystal_ready_flag)
    else $error("pll lock timer not started");
  settle_run_a: assert property (start_settle |=>
    !fast_internal_stable_flag ##CSD_CYC !exec_hold)
    else $error("settle time held execution");
  prim_ready_a: assert property (wake_go && pre_src == PRE_PRIMARY &&
    post_src != POST_FAST |=> crystal_ready_flag && exec_hold)
    else $error("primary wake ready flag wrong");
  freq_rst_a: assert property (disable iff (1'b0) !aresetn |=>
    fast_osc_freq_sel == FREQ_1MHZ) else $error("freq reset value");
  rcc_rst_a: assert property (disable iff (1'b0) !aresetn |=>
    rcc_q == RCC_RST) else $error("status reset value");
  wdog_flag_a: assert property (wdt_timeout |=>
    !rcc_q[B_WDOG]) else $error("watchdog flag not cleared");
  sleep_flag_a: assert property (sleep_instr && !wdt_timeout |=>
    !rcc_q[B_SLEEP] && rcc_q[B_WDOG]) else $error("sleep flags wrong");
  dip_flag_a: assert property (brownout_evt && !wr_rcc |=>
    !rcc_q[B_DIP] && $stable(rcc_q[B_PWRUP]))
    else $error("brownout flags wrong");
  instr_win_a: assert property (reset_instr && wr_rcc |=>
    !rcc_q[B_INSTR]) else $error("software set beat event");
  swbo_gate_a: assert property (brownout_config_field == BO_CFG_SW |=>
    brownout_enable == $past(rcc_q[B_SWBO]))
    else $error("software brownout not followed");
  prio_wr_a: assert property (wr_rcc |=>
    priority_levels_enable == $past(wdata_q[B_PRIO]))
    else $error("priority enable not written");
  ext_pm_a: assert property (ext_fall && pm_mode && !stack_underflow &&
    !stack_full && !reset_instr && !brownout_evt && !wdt_timeout |=>
    cause_q == CAUSE_EXT_PM) else $error("pin reset cause wrong");

  pll_wake_c: cover property (st_q == ST_PLL && tmr.done[T_PLL]);
  settle_c: cover property (start_settle);
  rd_clear_c: cover property (rd_stat && |stat_q);
endmodule // wdr_top

// *** sim/testbench.sv ***
// self-checking bench for the wake delay and reset status block
`timescale 1ns/1ps
module testbench;
  import wdr_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} wdr_exp_s;
  // ------------------------------------------------------------------
  // stimulus tables and signals
  // ------------------------------------------------------------------
  localparam int PLL_T = 20;
  // settle longer than the cpu delay shows execution resumes first
  localparam int SET_T = 300;
  localparam logic [2:0] CZ[7] = '{CAUSE_INSTR, CAUSE_DIP, CAUSE_WDT,
    CAUSE_STK_FULL, CAUSE_STK_UNDER, CAUSE_EXT_RUN, CAUSE_EXT_PM};
  localparam logic [7:0] CLR[7] = '{8'h10, 8'h01, 8'h08, 8'h00, 8'h00,
    8'h04, 8'h00};
  localparam logic [7:0] SET[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h08, 8'h0c};
  localparam wdr_pre_e WPRE[7] = '{PRE_PRIMARY, PRE_PRIMARY, PRE_SLOW,
    PRE_NONE, PRE_FAST, PRE_FAST, PRE_SLOW};
  localparam wdr_post_e WPOST[7] = '{POST_CRYSTAL, POST_FAST, POST_CRYSTAL,
    POST_PLL, POST_EXT, POST_FAST, POST_FAST};
  localparam int WHOLD[7] = '{CSD_CYC, CSD_CYC, OSC_CYC, OSC_CYC + PLL_T,
    CSD_CYC, 0, CSD_CYC};
  // fast stable stays set until a later settle restarts it
  localparam logic [1:0] WFLG[7] = '{2'h2, 2'h1, 2'h3, 2'h3, 2'h3, 2'h1,
    2'h1};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wake_req, pm_mode, pin_n;
  logic exec_hold, xrdy, frdy, prio, bo_en, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bo_cfg;
  logic [6:0] ev;
  logic [FREQ_W-1:0] freq, v;
  logic [7:0] rcc;
  wdr_pre_e pre_src;
  wdr_post_e post_src;
  wdr_exp_s rq[$];
  wdr_exp_s me;
  logic [1:0] bq[$];
  int error_cnt = 0;
  int compares = 0;
  int n;

  wdr_top #(.PLL_CYC(PLL_T), .SETTLE_CYC(SET_T)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .wake_req(wake_req),
    .pre_src(pre_src), .post_src(post_src), .pm_mode(pm_mode),
    .external_reset_pin_n(pin_n), .wdt_timeout(ev[2]),
    .clrwdt_instr(ev[6]), .sleep_instr(ev[5]), .reset_instr(ev[0]),
    .brownout_evt(ev[1]), .stack_full(ev[3]), .stack_underflow(ev[4]),
    .brownout_config_field(bo_cfg), .exec_hold(exec_hold),
    .crystal_ready_flag(xrdy), .fast_internal_stable_flag(frdy),
    .fast_osc_freq_sel(freq), .priority_levels_enable(prio),
    .brownout_enable(bo_en), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ------------------------------------------------------------------
  // bus tasks and checking
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ready sampled at the negedge holds at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    fork
      begin
        do @(negedge aclk); while (awready !== 1'b1);
        @(posedge aclk);
        awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (wready !== 1'b1);
        @(posedge aclk);
        wvalid <= 1'b0;
      end
    join
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] r);
    rq.push_back('{d, m, r});
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(negedge aclk);
  endtask

  always @(negedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      me = rq.pop_front();
      chk({30'h0, rresp}, {30'h0, me.r});
      chk(rdata & me.m, me.d);
    end
    if (bvalid === 1'b1 && bready === 1'b1)
      chk({30'h0, bresp}, {30'h0, bq.pop_front()});
  end

  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, wake_req} = '0;
    {awaddr, araddr, wdata, ev, pm_mode} = '0;
    wstrb = 4'hf;
    pin_n = 1'b1;
    bo_cfg = BO_CFG_SW;
    pre_src = PRE_PRIMARY;
    post_src = POST_CRYSTAL;
    void'($urandom(32'hb5efd825));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rcc = 8'h5c;
    rd(A_RCC, {24'h0, rcc}, 32'hffff_ffff, RESP_OK);
    rd(A_OSC, 32'h0000_0003, 32'h0000_0707, RESP_OK);
    for (int i = 0; i < 2; i++) begin
      wr(A_RCC, i ? 32'h0000_00ff : 32'h0, RESP_OK);
      rcc = (rcc & 8'h0c) | (i ? 8'hd3 : 8'h00);
      rd(A_RCC, {24'h0, rcc}, 32'hffff_ffff, RESP_OK);
      settle();
      chk({31'h0, prio}, {31'h0, rcc[7]});
      chk({31'h0, bo_en}, {31'h0, rcc[6]});
    end
    @(posedge aclk);
    bo_cfg <= 2'h2;
    settle();
    chk({31'h0, bo_en}, 32'h1);
    @(posedge aclk);
    bo_cfg <= BO_CFG_OFF;
    settle();
    chk({31'h0, bo_en}, 32'h0);
    for (int k = 0; k < 7; k++) begin
      @(posedge aclk);
      ev <= 7'h01 << k;
      @(posedge aclk);
      ev <= '0;
      rcc = (rcc & ~CLR[k]) | SET[k];
      rd(A_RCC, {24'h0, rcc}, 32'hff, RESP_OK);
      if (k < 5) rd(A_OSC, {17'h0, CZ[k], 12'h0}, 32'h7000, RESP_OK);
      wr(A_RCC, {24'h0, rcc | 8'h13}, RESP_OK);
      rcc = rcc | 8'h13;
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge aclk);
      pm_mode <= p[0];
      pin_n <= 1'b0;
      repeat (4) @(posedge aclk);
      pin_n <= 1'b1;
      pm_mode <= 1'b0;
      rd(A_OSC, {17'h0, CZ[5 + p], 12'h0}, 32'h7000, RESP_OK);
    end
    // reset instruction lands in the very cycle the write is applied
    fork
      wr(A_RCC, {24'h0, rcc}, RESP_OK);
      begin
        repeat (2) @(posedge aclk);
        ev <= 7'h01;
        @(posedge aclk);
        ev <= '0;
      end
    join
    rcc = rcc & 8'hef;
    rd(A_RCC, {24'h0, rcc}, 32'hff, RESP_OK);
    for (int j = 0; j < 7; j++) begin
      @(posedge aclk);
      pre_src <= WPRE[j];
      post_src <= WPOST[j];
      wake_req <= 1'b1;
      @(posedge aclk);
      wake_req <= 1'b0;
      n = 0;
      repeat (1100) begin
        @(negedge aclk);
        n += (exec_hold === 1'b1);
      end
      chk(n, WHOLD[j]);
      chk({30'h0, xrdy, frdy}, {30'h0, WFLG[j]});
    end
    chk({31'h0, irq}, 32'h0);
    wr(A_MASK, 32'h0000_0001, RESP_OK);
    settle();
    chk({31'h0, irq}, 32'h1);
    rd(A_STAT, 32'h0000_0001, 32'h0000_0001, RESP_OK);
    settle();
    chk({31'h0, irq}, 32'h0);
    repeat (4) begin
      v = 3'($urandom());
      wr(A_OSC, {29'h0, v}, RESP_OK);
      rd(A_OSC, {29'h0, v}, 32'h0000_0007, RESP_OK);
    end
    rd(8'h10, 32'h0, 32'hffff_ffff, RESP_ERR);
    wr(8'h10, 32'h0000_00ff, RESP_ERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk({29'h0, freq}, {29'h0, FREQ_1MHZ});
    rd(A_RCC, 32'h0000_005c, 32'hffff_ffff, RESP_OK);
    complete_run();
  end
endmodule // testbench
